// >>> fsls_top.sv
// fault supervision and status lamp signaler top
//
// Operation
// [R01] Over 75 C on power board: power stage off, error bit set.
// [R02] Shutdown latched until cooled and host fault-clear command arrives.
// [R03] No error: green lamp, one short flash each second.
// [R04] Error active: red lamp, flashes repeated equal to class number.
// [R05] Classes: 1 general,2 voltage,3 temperature,4 overcurrent,5 controller,6 watchdog.
// [R06] Every error stores a detailed code in the error history; a report in the same cycle as a new overtemp is not stored.
// [R07] Lamp-disable configuration bit turns the lamp fully off.
// [R08] Over-temperature shows as class 3; pause separates repeated bursts.
`timescale 1ns/1ns
module fsls_top
	import fsls_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic overTemp,
	input wire logic faultClear,
	input wire logic lampDisable,
	input wire logic errReport,
	input wire logic [2:0] errReportClass,
	input wire logic [15:0] errReportCode,
	output logic powerEnable,
	output logic errorBit,
	output logic [2:0] errClass,
	output fsls_err_t histEntry,
	output fsls_lamp_t statusLamp
);
	// ---------------------------------------------------------------
	// overTemp pin synchroniser
	// ---------------------------------------------------------------
	logic [1:0] otSync_q;
	logic otHot;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			otSync_q <= 2'h0;
		end else begin
			otSync_q <= {otSync_q[0], overTemp};
		end
	end
	assign otHot = otSync_q[1];

	// ---------------------------------------------------------------
	// fault latch
	// ---------------------------------------------------------------
	logic errActive_q;
	logic [2:0] cls_q;
	logic newErr;
	logic otNew;
	logic clrOk;

	function automatic logic clsValid(input logic [2:0] c);
		return c != CLS_NONE && c <= CLS_MAX;
	endfunction

	assign otNew = otHot && !(errActive_q && cls_q == CLS_TEMP);
	assign newErr = otNew || (errReport && clsValid(errReportClass));
	// clear refused while still hot, so the set always wins
	assign clrOk = faultClear && !otHot;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			errActive_q <= 1'b0;
			cls_q <= CLS_NONE;
		end else if (otNew) begin
			// [R01] latch overtemp error
			// [R08] overtemp is class 3
			errActive_q <= 1'b1;
			cls_q <= CLS_TEMP;
		end else if (errReport && clsValid(errReportClass)) begin
			// [R05] class taken as reported unless class 3 is already latched
			errActive_q <= 1'b1;
			if (cls_q != CLS_TEMP) begin
				cls_q <= errReportClass;
			end
		end else if (clrOk) begin
			// [R02] clear only once cooled
			errActive_q <= 1'b0;
			cls_q <= CLS_NONE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			powerEnable <= 1'b0;
		end else begin
			// [R01] power stage off while tripped
			powerEnable <= !(errActive_q && cls_q == CLS_TEMP) && !otHot;
		end
	end

	assign errorBit = errActive_q;
	assign errClass = cls_q;

	// ---------------------------------------------------------------
	// error history output
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			histEntry <= '0;
		end else if (otNew) begin
			// [R06] store detail code
			histEntry <= '{valid: 1'b1, cls: CLS_TEMP, code: CODE_OVERTEMP};
		end else if (errReport && clsValid(errReportClass)) begin
			histEntry <= '{valid: 1'b1, cls: errReportClass, code: errReportCode};
		end else begin
			histEntry.valid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// lamp
	// ---------------------------------------------------------------
	fsls_flasher uFlasher (
		.clk(clk),
		.nrst(nrst),
		.errClass(cls_q),
		.lampOff(lampDisable),
		.lamp(statusLamp)
	);

	// ---------------------------------------------------------------
	// checks: shutdown latch
	// ---------------------------------------------------------------
	sequence s_hot;
		otHot;
	endsequence
	sequence s_tripped;
		errActive_q && cls_q == CLS_TEMP;
	endsequence
	sequence s_cool_clear;
		!otHot && faultClear;
	endsequence
	sequence s_report_ok;
		errReport && clsValid(errReportClass);
	endsequence

	// sync lag check skips the first two edges after reset
	// [R01] two-edge synchroniser lag
	a_sync_lag: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst, 2) |-> otHot == $past(overTemp, 2)) else $error("overtemp sync lag wrong"); // [R01]
	// [R01] trip one edge after hot
	a_ot_trips: assert property (@(posedge clk) disable iff (!nrst)
		s_hot |=> s_tripped) else $error("overtemp not latched"); // [R01]
	// [R01] power cut while hot
	a_power_hot: assert property (@(posedge clk) disable iff (!nrst)
		s_hot |=> !powerEnable) else $error("power on while hot"); // [R01]
	// [R01] power stays off
	a_power_off: assert property (@(posedge clk) disable iff (!nrst)
		s_tripped |=> !powerEnable) else $error("power on while tripped"); // [R01]
	// [R02] power back when cool
	a_power_up: assert property (@(posedge clk) disable iff (!nrst)
		!(errActive_q && cls_q == CLS_TEMP) && !otHot |=> powerEnable) else $error("power not restored"); // [R02]
	// [R02] shutdown held while hot
	a_hold_hot: assert property (@(posedge clk) disable iff (!nrst)
		s_tripped ##0 (otHot || !faultClear) |=> s_tripped) else $error("shutdown left early"); // [R02]
	// [R02] clear refused while hot
	a_clear_hot_no: assert property (@(posedge clk) disable iff (!nrst)
		errActive_q && faultClear && otHot |=> errorBit) else $error("clear taken while hot"); // [R02]
	// [R02] cool clear accepted
	a_clear_ok: assert property (@(posedge clk) disable iff (!nrst)
		errActive_q ##0 s_cool_clear ##0 !newErr |=> !errorBit) else $error("clear ignored"); // [R02]
	// [R02] error stands until clear
	a_err_stands: assert property (@(posedge clk) disable iff (!nrst)
		errActive_q && !clrOk |=> errorBit) else $error("error dropped without clear"); // [R02]
	// [R02] new error beats clear
	a_set_wins: assert property (@(posedge clk) disable iff (!nrst)
		s_report_ok ##0 faultClear |=> errorBit) else $error("clear beat a new error"); // [R02]
	// [R02] no class without error
	a_none_idle: assert property (@(posedge clk) disable iff (!nrst)
		!errorBit |-> errClass == CLS_NONE) else $error("class shown without error"); // [R02]

	// ---------------------------------------------------------------
	// checks: error class
	// ---------------------------------------------------------------
	// [R08] temperature class sticky
	a_temp_sticky: assert property (@(posedge clk) disable iff (!nrst)
		s_tripped ##0 s_report_ok |=> errClass == CLS_TEMP) else $error("temperature class overridden"); // [R08]
	// [R05] reported class taken
	a_class_taken: assert property (@(posedge clk) disable iff (!nrst)
		s_report_ok ##0 (!otNew && cls_q != CLS_TEMP) |=> errClass == $past(errReportClass))
		else $error("reported class not shown"); // [R05]
	// [R05] class in legal range
	a_class_legal: assert property (@(posedge clk) disable iff (!nrst)
		errorBit |-> errClass != CLS_NONE && errClass <= CLS_MAX) else $error("class out of range"); // [R05]
	// [R05] illegal class ignored
	a_bad_class_kept: assert property (@(posedge clk) disable iff (!nrst)
		errReport && !clsValid(errReportClass) && !otNew && !clrOk |=> errClass == $past(errClass))
		else $error("illegal class accepted"); // [R05]

	// ---------------------------------------------------------------
	// checks: error history
	// ---------------------------------------------------------------
	// [R06] every new-error cycle logs a history entry
	a_hist_log: assert property (@(posedge clk) disable iff (!nrst)
		newErr |=> histEntry.valid) else $error("error not logged"); // [R06]
	// [R06] overtemp detail code
	a_hist_temp: assert property (@(posedge clk) disable iff (!nrst)
		otNew |=> histEntry.cls == CLS_TEMP && histEntry.code == CODE_OVERTEMP) else $error("overtemp code wrong"); // [R06]
	// [R06] reported detail code
	a_hist_report: assert property (@(posedge clk) disable iff (!nrst)
		s_report_ok ##0 !otNew |=> histEntry.cls == $past(errReportClass) && histEntry.code == $past(errReportCode))
		else $error("reported code wrong"); // [R06]
	// [R06] valid is a single pulse
	a_hist_pulse: assert property (@(posedge clk) disable iff (!nrst)
		!newErr |=> !histEntry.valid) else $error("history valid without error"); // [R06]

	// ---------------------------------------------------------------
	// checks: lamp
	// ---------------------------------------------------------------
	// the lamp flop lags the latch by one edge, hence the past values
	// burst lengths run to millions of cycles, so only colour is checked here
	// [R03] green only without error
	a_green_ok: assert property (@(posedge clk) disable iff (!nrst)
		statusLamp.green |-> !$past(errorBit)) else $error("green lamp during error"); // [R03]
	// [R04] red only with error
	a_red_err: assert property (@(posedge clk) disable iff (!nrst)
		statusLamp.red |-> $past(errorBit)) else $error("red lamp without error"); // [R04]
	// [R07] disable darkens the lamp
	a_lamp_dark: assert property (@(posedge clk) disable iff (!nrst)
		lampDisable |=> statusLamp == '0) else $error("lamp lit while disabled"); // [R07]
endmodule

// >>> fsls_pkg.sv
// shared constants and types for the fault status lamp signaler
package fsls_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 250000000;
	localparam int PERIOD_MS = 1000;
	localparam int FLASH_MS = 100;
	localparam int GAP_MS = 300;
	localparam int PAUSE_MS = 1500;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int PERIOD_CYC = PERIOD_MS * MS_CYCLES;
	localparam int FLASH_CYC = FLASH_MS * MS_CYCLES;
	localparam int GAP_CYC = GAP_MS * MS_CYCLES;
	localparam int PAUSE_CYC = PAUSE_MS * MS_CYCLES;
	localparam int CNT_W = 32;

	// ---------------------------------------------------------------
	// error classes shown as flash counts
	// ---------------------------------------------------------------
	localparam logic [2:0] CLS_NONE = 3'h0;
	localparam logic [2:0] CLS_GENERAL = 3'h1;
	localparam logic [2:0] CLS_VOLTAGE = 3'h2;
	localparam logic [2:0] CLS_TEMP = 3'h3;
	localparam logic [2:0] CLS_OVERCUR = 3'h4;
	localparam logic [2:0] CLS_CTRL = 3'h5;
	localparam logic [2:0] CLS_WDOG = 3'h6;
	localparam logic [2:0] CLS_MAX = 3'h6;

	localparam logic [15:0] CODE_OVERTEMP = 16'h4310;

	typedef struct packed {
		logic green;
		logic red;
	} fsls_lamp_t;

	typedef struct packed {
		logic valid;
		logic [2:0] cls;
		logic [15:0] code;
	} fsls_err_t;
endpackage

// >>> fsls_flasher.sv
// lamp flash sequencer: single green blink or red burst plus pause
`timescale 1ns/1ns
module fsls_flasher
	import fsls_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [2:0] errClass,
	input wire logic lampOff,
	output fsls_lamp_t lamp
);
	typedef enum logic [1:0] {FSLS_ON, FSLS_GAP, FSLS_PAUSE} fsls_fl_t;

	fsls_fl_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [2:0] flashes_q;
	logic [2:0] cls_q;
	logic isErr;

	assign isErr = (errClass != CLS_NONE);

	function automatic logic [CNT_W-1:0] cyc(input int n);
		return CNT_W'(n - 1);
	endfunction

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= FSLS_ON;
			// full-length first blink, not a one-cycle glint after reset
			cnt_q <= CNT_W'(FLASH_CYC - 1);
			flashes_q <= 3'h0;
			cls_q <= CLS_NONE;
		end else if (errClass != cls_q) begin
			// restart so a new class never shows a mixed burst
			state_q <= FSLS_ON;
			cnt_q <= cyc(FLASH_CYC);
			flashes_q <= 3'h1;
			cls_q <= errClass;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else begin
			case (state_q)
				FSLS_ON: begin
					if (!isErr) begin
						// [R03] one blink per second
						state_q <= FSLS_PAUSE;
						cnt_q <= cyc(PERIOD_CYC - FLASH_CYC);
					end else if (flashes_q >= cls_q) begin
						// [R08] pause after burst
						state_q <= FSLS_PAUSE;
						cnt_q <= cyc(PAUSE_CYC);
					end else begin
						state_q <= FSLS_GAP;
						cnt_q <= cyc(GAP_CYC);
					end
				end
				FSLS_GAP: begin
					state_q <= FSLS_ON;
					cnt_q <= cyc(FLASH_CYC);
					flashes_q <= flashes_q + 3'h1;
				end
				default: begin
					state_q <= FSLS_ON;
					cnt_q <= cyc(FLASH_CYC);
					flashes_q <= 3'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lamp <= '0;
		end else begin
			// [R07] lamp disable wins
			// [R04] red while an error is active
			lamp.green <= !lampOff && !isErr && state_q == FSLS_ON && cls_q == errClass;
			lamp.red <= !lampOff && isErr && state_q == FSLS_ON && cls_q == errClass;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_lamp_off_dark: assert property (@(posedge clk) disable iff (!nrst)
		$past(lampOff) |-> lamp == '0) else $error("lamp lit while disabled"); // [R07]
	a_red_only_err: assert property (@(posedge clk) disable iff (!nrst)
		lamp.red |-> $past(isErr)) else $error("red without error"); // [R04]
	a_green_only_ok: assert property (@(posedge clk) disable iff (!nrst)
		lamp.green |-> $past(!isErr)) else $error("green during error"); // [R03]
	a_burst_bound: assert property (@(posedge clk) disable iff (!nrst)
		flashes_q <= CLS_MAX) else $error("flash count out of range"); // [R05]
endmodule

// >>> test_fault_status_led_signaler.sv
// self-checking bench for the fault status lamp signaler
`timescale 1ns/1ns
module test_fault_status_led_signaler;
	import fsls_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic overTemp = 1'b0;
	logic faultClear = 1'b0;
	logic lampDisable = 1'b0;
	logic errReport = 1'b0;
	logic [2:0] errReportClass = 3'h0;
	logic [15:0] errReportCode = 16'h0;
	logic powerEnable;
	logic errorBit;
	logic [2:0] errClass;
	fsls_err_t histEntry;
	fsls_lamp_t statusLamp;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic seen;

	always #2 clk = ~clk;

	fsls_top uut (
		.clk(clk),
		.nrst(nrst),
		.overTemp(overTemp),
		.faultClear(faultClear),
		.lampDisable(lampDisable),
		.errReport(errReport),
		.errReportClass(errReportClass),
		.errReportCode(errReportCode),
		.powerEnable(powerEnable),
		.errorBit(errorBit),
		.errClass(errClass),
		.histEntry(histEntry),
		.statusLamp(statusLamp)
	);

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		if (n_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// report pulse, optionally with a clear in the same cycle; history stands one cycle only
	task automatic report(input logic [2:0] cls, input logic [15:0] code, input logic clr);
		@(negedge clk);
		errReport = 1'b1;
		errReportClass = cls;
		errReportCode = code;
		faultClear = clr;
		@(negedge clk);
		errReport = 1'b0;
		faultClear = 1'b0;
		seen = (histEntry.valid === 1'b1);
		if (seen) begin
			check(histEntry, {1'b1, cls, code});
		end
	endtask

	task automatic clear;
		@(negedge clk);
		faultClear = 1'b1;
		@(negedge clk);
		faultClear = 1'b0;
		tick(3);
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		tick(4);
		check(20'({powerEnable, errorBit, errClass, statusLamp}), 20'h0);
		nrst = 1'b1;
		tick(2);
		check(20'({powerEnable, errorBit, errClass}), 20'h10);
		check(20'(statusLamp), 20'h2);
		// over-temperature: two edges through the synchroniser, the third trips and cuts power
		overTemp = 1'b1;
		tick(2);
		check(20'({powerEnable, errorBit}), 20'h2);
		tick(1);
		check(20'({errorBit, errClass}), 20'({1'b1, CLS_TEMP}));
		check(histEntry, {1'b1, CLS_TEMP, CODE_OVERTEMP});
		check(20'(powerEnable), 20'h0);
		tick(1);
		check(20'(powerEnable), 20'h0);
		tick(2);
		check(20'(statusLamp), 20'h1);
		clear();
		check(20'({powerEnable, errorBit}), 20'h1);
		report(CLS_VOLTAGE, 16'h3210, 1'b0);
		check(20'(seen), 20'h1);
		check(20'(errClass), 20'(CLS_TEMP));
		overTemp = 1'b0;
		tick(4);
		check(20'(errorBit), 20'h1);
		clear();
		check(20'({powerEnable, errorBit, errClass}), 20'h10);
		// every class once, each cleared afterwards
		for (int c = 1; c <= 6; c++) begin
			report(c[2:0], 16'h1000 + 16'(c), 1'b0);
			check(20'(seen), 20'h1);
			tick(2);
			check(20'({errorBit, errClass}), 20'({1'b1, c[2:0]}));
			check(20'(statusLamp), 20'h1);
			clear();
			check(20'({errorBit, errClass}), 20'h0);
		end
		report(3'h7, 16'hBEEF, 1'b0);
		check(20'({seen, errorBit}), 20'h0);
		// clear in the same cycle as a new error: the error stays
		report(CLS_OVERCUR, 16'h2310, 1'b1);
		check(20'({errorBit, errClass}), 20'({1'b1, CLS_OVERCUR}));
		lampDisable = 1'b1;
		tick(3);
		check(20'(statusLamp), 20'h0);
		lampDisable = 1'b0;
		clear();
		tick(3);
		check(20'(statusLamp), 20'h2);
		close_out();
	end
endmodule
